// ===== design/resolver_status_preset_logic.sv
/*
  Status indication and position preset for a two channel resolver
  module: Avalon-MM register slave, blink timer, module and network
  indicators and two channel units.
  Assumes synchronous inputs, a 250 MHz ref_clk and an Avalon master that
  holds each request until it samples waitrequest low.
*/
`timescale 1ns/10ps
module resolver_status_preset_logic #(
  parameter int POS_W        = resolver_pkg::POS_W,
  parameter int BLINK_CYCLES = resolver_pkg::BLINK_HALF_CYCLES
) (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_b,
  // Avalon-MM slave
  input  wire logic [4:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,
  // Channel inputs, bit 0 first_channel, bit 1 second_channel
  input  wire logic [1:0]          dc_active,
  input  wire logic [1:0]          pos_valid,
  input  wire logic [POS_W-1:0]    first_channel_pos,
  input  wire logic [POS_W-1:0]    second_channel_pos,
  input  wire logic [1:0]          soft_fault,
  input  wire logic [1:0]          hard_fault,
  // Module and network conditions
  input  wire logic                module_fault,
  input  wire logic                coproc_comm_fail,
  input  wire logic                phy_link_up,
  input  wire logic                net_operational,
  input  wire logic                addr_changed,
  input  wire logic                nv_write_fail,
  input  wire logic                dup_ip_detected,
  input  wire logic                proto_ethernet_ip,
  // Indicators
  output logic [1:0]               chan_led_red,
  output logic [1:0]               chan_led_green,
  output logic                     module_health_indicator_red,
  output logic                     module_health_indicator_green,
  output logic                     network_link_indicator_red,
  output logic                     network_link_indicator_green
);
  import resolver_pkg::*;

  localparam int BW = $clog2(BLINK_CYCLES);
  localparam logic [BW-1:0] BLINK_LAST = BW'(BLINK_CYCLES - 1);

  logic [CTRL_STORE_W-1:0] ctrl;          // Disable and latch bits
  logic [1:0]              apply_pulse;   // Apply preset strobes
  logic                    clear_pulse;   // Clear latched faults
  logic [POS_W-1:0]        fs0;           // First channel full scale
  logic [POS_W-1:0]        fs1;           // Second channel full scale
  logic [POS_W-1:0]        pre0;          // First channel preset
  logic [POS_W-1:0]        pre1;          // Second channel preset
  logic [POS_W-1:0]        pos0;          // First channel position
  logic [POS_W-1:0]        pos1;          // Second channel position
  logic [1:0]              fault_latched; // Latched clearable faults
  logic [BW-1:0]           blink_cnt;     // Blink half period counter
  logic                    blink_on;      // Blink phase
  logic                    comm_latched;  // Coprocessor failure seen
  logic                    addr_latched;  // Address/protocol change seen
  logic                    nv_latched;    // Flash write failure seen
  led_mode_t               ms_mode;       // Module indicator mode
  led_mode_t               ns_mode;       // Network indicator mode
  logic                    wr_take;       // Write completes this edge
  logic [31:0]             next_readdata; // Read mux
  logic [POS_W-1:0]        wr_val;        // Write data at position width
  logic [POS_W-1:0]        fs_val;        // Full scale kept at or above minimum

  assign wr_take = avs_write && !avs_waitrequest;
  assign wr_val  = avs_writedata[POS_W-1:0];
  assign fs_val  = (wr_val < FS_MIN) ? FS_MIN : wr_val;

  // Waitrequest: one wait cycle, then a single ready cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Read mux, address bits 1:0 ignored so every offset maps to a register
  always_comb begin
    next_readdata = 32'h0000_0000;
    case (avs_address & 5'h1C)
      OFS_CTRL:   next_readdata[CTRL_STORE_W-1:0] = ctrl;
      OFS_FS0:    next_readdata[POS_W-1:0] = fs0;
      OFS_PRE0:   next_readdata[POS_W-1:0] = pre0;
      OFS_FS1:    next_readdata[POS_W-1:0] = fs1;
      OFS_PRE1:   next_readdata[POS_W-1:0] = pre1;
      OFS_POS0:   next_readdata[POS_W-1:0] = pos0;
      OFS_POS1:   next_readdata[POS_W-1:0] = pos1;
      OFS_STATUS: next_readdata[7:0] = {blink_on, nv_latched,
                                        addr_latched, comm_latched,
                                        fault_latched, dc_active};
      default:    next_readdata = 32'h0000_0000;
    endcase
  end

  // Read data captured in the wait cycle, held on the ready cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= next_readdata;
    end
  end

  // Control register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= '0;
    end else if (wr_take && (avs_address & 5'h1C) == OFS_CTRL) begin
      ctrl <= avs_writedata[CTRL_STORE_W-1:0];
    end
  end

  // Apply and clear strobes last one cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      apply_pulse <= 2'h0;
      clear_pulse <= 1'b0;
    end else if (wr_take && (avs_address & 5'h1C) == OFS_CTRL) begin
      apply_pulse <= avs_writedata[CTRL_APPLY+1:CTRL_APPLY];
      clear_pulse <= avs_writedata[CTRL_CLEAR];
    end else begin
      apply_pulse <= 2'h0;
      clear_pulse <= 1'b0;
    end
  end

  // Full scale and preset registers; preset clamped on write
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fs0  <= FS_RESET;
      fs1  <= FS_RESET;
      pre0 <= PRESET_RESET;
      pre1 <= PRESET_RESET;
    end else if (wr_take) begin
      case (avs_address & 5'h1C)
        OFS_FS0:  fs0  <= fs_val;
        OFS_FS1:  fs1  <= fs_val;
        OFS_PRE0: pre0 <= (wr_val < fs0) ? wr_val : fs0 - 1'b1;
        OFS_PRE1: pre1 <= (wr_val < fs1) ? wr_val : fs1 - 1'b1;
        default: ;
      endcase
    end
  end

  // Blink timer shared by every indicator so all lamps flash together
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      blink_cnt <= '0;
      blink_on  <= 1'b0;
    end else if (blink_cnt == BLINK_LAST) begin
      blink_cnt <= '0;
      blink_on  <= !blink_on;
    end else begin
      blink_cnt <= blink_cnt + 1'b1;
    end
  end

  // Fault memories cleared only by reset, i.e. by a power cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      comm_latched <= 1'b0;
      addr_latched <= 1'b0;
      nv_latched   <= 1'b0;
    end else begin
      comm_latched <= comm_latched || coproc_comm_fail;
      addr_latched <= addr_latched || addr_changed;
      nv_latched   <= nv_latched || nv_write_fail;
    end
  end

  // Module indicator mode
  always_comb begin
    if (comm_latched) begin
      ms_mode = LED_ALT;
    end else if (addr_latched || nv_latched) begin
      ms_mode = LED_BLINK_RED;
    end else if (!phy_link_up) begin
      ms_mode = LED_BLINK_GREEN;
    end else if (net_operational) begin
      ms_mode = LED_GREEN;
    end else begin
      ms_mode = LED_BLINK_GREEN;  // Still initialising
    end
  end

  // Network indicator mode
  always_comb begin
    if (addr_latched) begin
      ns_mode = LED_BLINK_RED;
    end else if (!proto_ethernet_ip) begin
      ns_mode = LED_OFF;
    end else if (dup_ip_detected) begin
      ns_mode = LED_RED;
    end else if (net_operational) begin
      ns_mode = LED_GREEN;
    end else if (phy_link_up) begin
      ns_mode = LED_BLINK_GREEN;
    end else begin
      ns_mode = LED_OFF;
    end
  end

  // Module and network lamps from flip-flops
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      module_health_indicator_red   <= 1'b0;
      module_health_indicator_green <= 1'b0;
      network_link_indicator_red    <= 1'b0;
      network_link_indicator_green  <= 1'b0;
    end else begin
      module_health_indicator_red   <= led_red_of(ms_mode, blink_on);
      module_health_indicator_green <= led_green_of(ms_mode, blink_on);
      network_link_indicator_red    <= led_red_of(ns_mode, blink_on);
      network_link_indicator_green  <= led_green_of(ns_mode, blink_on);
    end
  end

  // First channel
  channel_preset_unit #(.POS_W(POS_W)) u_first_channel (
    .ref_clk      (ref_clk),
    .rst_b        (rst_b),
    .dc_active    (dc_active[0]),
    .apply_preset (apply_pulse[0]),
    .preset_value (pre0),
    .full_scale   (fs0),
    .pos_valid    (pos_valid[0]),
    .pos_value    (first_channel_pos),
    .latch_en     (ctrl[CTRL_LATCH]),
    .clear_fault  (clear_pulse),
    .soft_fault   (soft_fault[0]),
    .hard_fault   (hard_fault[0]),
    .module_fault (module_fault),
    .disabled     (ctrl[CTRL_DIS]),
    .blink_on     (blink_on),
    .position     (pos0),
    .fault_latched(fault_latched[0]),
    .led_red      (chan_led_red[0]),
    .led_green    (chan_led_green[0])
  );

  // Second channel
  channel_preset_unit #(.POS_W(POS_W)) u_second_channel (
    .ref_clk      (ref_clk),
    .rst_b        (rst_b),
    .dc_active    (dc_active[1]),
    .apply_preset (apply_pulse[1]),
    .preset_value (pre1),
    .full_scale   (fs1),
    .pos_valid    (pos_valid[1]),
    .pos_value    (second_channel_pos),
    .latch_en     (ctrl[CTRL_LATCH+1]),
    .clear_fault  (clear_pulse),
    .soft_fault   (soft_fault[1]),
    .hard_fault   (hard_fault[1]),
    .module_fault (module_fault),
    .disabled     (ctrl[CTRL_DIS+1]),
    .blink_on     (blink_on),
    .position     (pos1),
    .fault_latched(fault_latched[1]),
    .led_red      (chan_led_red[1]),
    .led_green    (chan_led_green[1])
  );

  property p_comm_alt;
    @(posedge ref_clk) disable iff (!rst_b)
      comm_latched |=> (module_health_indicator_red !=
                        module_health_indicator_green);
  endproperty
  a_comm_alt: assert property (p_comm_alt)
    else $error("comm failure not alternating");

  property p_comm_sticky;
    @(posedge ref_clk) disable iff (!rst_b)
      comm_latched |=> comm_latched [*4];
  endproperty
  a_comm_sticky: assert property (p_comm_sticky)
    else $error("comm failure cleared without reset");

  property p_no_link;
    @(posedge ref_clk) disable iff (!rst_b)
      (!comm_latched && !addr_latched && !nv_latched && !phy_link_up)
        |=> !module_health_indicator_red &&
            module_health_indicator_green == $past(blink_on);
  endproperty
  a_no_link: assert property (p_no_link)
    else $error("no link but module lamp not flashing green");

  property p_all_ok;
    @(posedge ref_clk) disable iff (!rst_b)
      (!comm_latched && !addr_latched && !nv_latched && phy_link_up &&
       net_operational)
        |=> module_health_indicator_green && !module_health_indicator_red;
  endproperty
  a_all_ok: assert property (p_all_ok)
    else $error("operational but module lamp not steady green");

  property p_addr_change;
    @(posedge ref_clk) disable iff (!rst_b)
      (addr_latched && !comm_latched)
        |=> module_health_indicator_red == $past(blink_on) &&
            network_link_indicator_red == $past(blink_on) &&
            !module_health_indicator_green;
  endproperty
  a_addr_change: assert property (p_addr_change)
    else $error("address change not flashing both lamps red");

  property p_nv_fail;
    @(posedge ref_clk) disable iff (!rst_b)
      (nv_latched && !addr_latched && !comm_latched)
        |=> module_health_indicator_red == $past(blink_on) &&
            !module_health_indicator_green &&
            network_link_indicator_red ==
              $past(proto_ethernet_ip && dup_ip_detected);
  endproperty
  a_nv_fail: assert property (p_nv_fail)
    else $error("flash write failure shown wrongly");

  property p_dup_ip;
    @(posedge ref_clk) disable iff (!rst_b)
      (proto_ethernet_ip && dup_ip_detected && !addr_latched)
        |=> network_link_indicator_red && !network_link_indicator_green;
  endproperty
  a_dup_ip: assert property (p_dup_ip)
    else $error("duplicate IP not steady red");

  c_comm_fail: cover property (@(posedge ref_clk) disable iff (!rst_b)
    !comm_latched ##1 comm_latched);
  c_addr_change: cover property (@(posedge ref_clk) disable iff (!rst_b)
    addr_latched && proto_ethernet_ip);
  c_dup_ip: cover property (@(posedge ref_clk) disable iff (!rst_b)
    dup_ip_detected && proto_ethernet_ip ##1 network_link_indicator_red);
  c_bus_write: cover property (@(posedge ref_clk) disable iff (!rst_b)
    wr_take);

endmodule // resolver_status_preset_logic

// ===== design/resolver_pkg.sv
/*
  Shared constants for the resolver status and preset logic: register
  offsets, control field positions, reset values, blink timing and the
  indicator mode type with its colour decoding.
  Assumes a 250 MHz ref_clk and a byte-addressed Avalon-MM register port.
*/
package resolver_pkg;

  // Position and full-scale width (largest multi-turn count fits)
  localparam int POS_W = 18;

  // Register byte offsets
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_FS0    = 5'h04;
  localparam logic [4:0] OFS_PRE0   = 5'h08;
  localparam logic [4:0] OFS_FS1    = 5'h0C;
  localparam logic [4:0] OFS_PRE1   = 5'h10;
  localparam logic [4:0] OFS_POS0   = 5'h14;
  localparam logic [4:0] OFS_POS1   = 5'h18;
  localparam logic [4:0] OFS_STATUS = 5'h1C;

  // Control register fields
  localparam int CTRL_DIS     = 0;  // Bits 1:0, channel disable
  localparam int CTRL_LATCH   = 2;  // Bits 3:2, fault latch enable
  localparam int CTRL_APPLY   = 4;  // Bits 5:4, apply preset (pulse)
  localparam int CTRL_CLEAR   = 6;  // Bit 6, clear latched faults (pulse)
  localparam int CTRL_STORE_W = 4;  // Stored control bits

  // Reset values
  localparam logic [POS_W-1:0] FS_RESET     = 18'h00400;
  localparam logic [POS_W-1:0] PRESET_RESET = 18'h00000;
  localparam logic [POS_W-1:0] FS_MIN       = 18'h00002;

  // Blink half period
  localparam int BLINK_HALF_MS     = 250;
  localparam int CLK_FREQ_KHZ      = 250_000;
  localparam int BLINK_HALF_CYCLES = BLINK_HALF_MS * CLK_FREQ_KHZ;

  // Indicator modes
  typedef enum logic [2:0] {
    LED_OFF         = 3'b000,
    LED_RED         = 3'b001,
    LED_GREEN       = 3'b010,
    LED_BLINK_RED   = 3'b011,
    LED_BLINK_GREEN = 3'b100,
    LED_ALT         = 3'b101
  } led_mode_t;

  // Red lamp for a mode at the present blink phase
  function automatic logic led_red_of(led_mode_t m, logic ph);
    return (m == LED_RED) || ((m == LED_BLINK_RED) && ph) ||
           ((m == LED_ALT) && ph);
  endfunction

  // Green lamp for a mode at the present blink phase
  function automatic logic led_green_of(led_mode_t m, logic ph);
    return (m == LED_GREEN) || ((m == LED_BLINK_GREEN) && ph) ||
           ((m == LED_ALT) && !ph);
  endfunction

endpackage

// ===== design/channel_preset_unit.sv
/*
  One resolver channel: DC input edge preset of the position, latched
  clearable transducer fault and the channel status indicator.
  Assumes synchronous inputs and a blink phase from the top module.
*/
`timescale 1ns/10ps
module channel_preset_unit #(
  parameter int POS_W = resolver_pkg::POS_W
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  // Preset sources
  input  wire logic             dc_active,
  input  wire logic             apply_preset,
  input  wire logic [POS_W-1:0] preset_value,
  input  wire logic [POS_W-1:0] full_scale,
  // Position from the decoder
  input  wire logic             pos_valid,
  input  wire logic [POS_W-1:0] pos_value,
  // Fault and enable conditions
  input  wire logic             latch_en,
  input  wire logic             clear_fault,
  input  wire logic             soft_fault,
  input  wire logic             hard_fault,
  input  wire logic             module_fault,
  input  wire logic             disabled,
  input  wire logic             blink_on,
  // Results
  output logic [POS_W-1:0]      position,
  output logic                  fault_latched,
  output logic                  led_red,
  output logic                  led_green
);
  import resolver_pkg::*;

  logic             dc_prev;     // Input level one cycle ago
  logic             dc_rise;     // Inactive to active step
  logic [POS_W-1:0] load_value;  // Preset kept inside full scale
  led_mode_t        mode;        // Indicator mode chosen this cycle

  // Active means conducting; the pin level already says so
  assign dc_rise = dc_active && !dc_prev;

  // Preset never reaches full scale
  assign load_value = (preset_value < full_scale) ? preset_value
                      : full_scale - 1'b1;

  // Remember the input level for edge detection
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dc_prev <= 1'b0;
    end else begin
      dc_prev <= dc_active;
    end
  end

  // Position: preset load wins over the decoder update
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      position <= PRESET_RESET;
    end else if (dc_rise || apply_preset) begin
      position <= load_value;
    end else if (pos_valid) begin
      position <= pos_value;
    end
  end

  // Latched fault: a new fault beats a clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_latched <= 1'b0;
    end else if (latch_en && soft_fault) begin
      fault_latched <= 1'b1;
    end else if (clear_fault || !latch_en) begin
      fault_latched <= 1'b0;
    end
  end

  // Indicator priority
  always_comb begin
    if (module_fault) begin
      mode = LED_RED;
    end else if (disabled) begin
      mode = LED_OFF;
    end else if (hard_fault) begin
      mode = LED_BLINK_RED;
    end else if (fault_latched) begin
      mode = LED_BLINK_GREEN;
    end else if (!soft_fault) begin
      mode = LED_GREEN;
    end else begin
      mode = LED_OFF;  // Self-clearing fault present
    end
  end

  // Drive the lamps from flip-flops
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      led_red   <= 1'b0;
      led_green <= 1'b0;
    end else begin
      led_red   <= led_red_of(mode, blink_on);
      led_green <= led_green_of(mode, blink_on);
    end
  end

  property p_dc_load;
    @(posedge ref_clk) disable iff (!rst_b)
      dc_rise |=> position == $past(load_value);
  endproperty
  a_dc_load: assert property (p_dc_load)
    else $error("position not preset on input edge");

  property p_preset_range;
    @(posedge ref_clk) disable iff (!rst_b)
      (dc_rise && full_scale >= FS_MIN) |=> position < $past(full_scale);
  endproperty
  a_preset_range: assert property (p_preset_range)
    else $error("preset load outside full scale");

  property p_disabled_off;
    @(posedge ref_clk) disable iff (!rst_b)
      (disabled && !module_fault) |=> !led_red && !led_green;
  endproperty
  a_disabled_off: assert property (p_disabled_off)
    else $error("disabled channel lamp lit");

  property p_module_red;
    @(posedge ref_clk) disable iff (!rst_b)
      module_fault |=> led_red && !led_green;
  endproperty
  a_module_red: assert property (p_module_red)
    else $error("module fault not solid red");

  property p_hard_blink;
    @(posedge ref_clk) disable iff (!rst_b)
      (hard_fault && !disabled && !module_fault)
        |=> !led_green && led_red == $past(blink_on);
  endproperty
  a_hard_blink: assert property (p_hard_blink)
    else $error("hard fault not blinking red");

  property p_latched_blink;
    @(posedge ref_clk) disable iff (!rst_b)
      (fault_latched && !hard_fault && !disabled && !module_fault)
        |=> !led_red && led_green == $past(blink_on);
  endproperty
  a_latched_blink: assert property (p_latched_blink)
    else $error("latched fault not blinking green");

  property p_solid_green;
    @(posedge ref_clk) disable iff (!rst_b)
      (!module_fault && !disabled && !hard_fault && !fault_latched &&
       !soft_fault) |=> led_green && !led_red;
  endproperty
  a_solid_green: assert property (p_solid_green)
    else $error("healthy channel not solid green");

  c_dc_load: cover property (@(posedge ref_clk) disable iff (!rst_b)
    dc_rise ##1 dc_active [*2]);

endmodule // channel_preset_unit

// ===== sim/field_side_model.sv
/*
  Field side: DC sensors whose current flow sets the input level.
  Assumes the bench drives sensor_current after each rising edge.
*/
`timescale 1ns/10ps
module field_side_model (
  // Sensor current and resulting input level
  input  wire logic [1:0] sensor_current,
  output logic [1:0]      dc_active
);
  // Input is active exactly while it conducts
  assign dc_active = sensor_current;
endmodule // field_side_model

// ===== sim/tb.sv
/*
  Bench for the status and preset block: Avalon tasks and scenarios.
  Assumes a short blink half period of 4 cycles and the field model.
*/
`timescale 1ns/10ps
module tb;
  import resolver_pkg::*;
  logic ref_clk = 0, rst_b = 0, rd = 0, wr = 0, wq, mf = 0, cf = 0;
  logic lk = 0, op = 0, ac = 0, di = 0, mr, mg, nr, ng;
  logic [4:0] adr = 0;
  logic [31:0] wd = 0, rdat, q;
  logic [1:0] cur = 0, dca, sf = 0, hf = 0, cr, cg;
  logic [7:0] lamps;
  logic nv = 0, pe = 1;
  logic [1:0] pv = 0;
  logic [POS_W-1:0] fp = 0;
  int n_fail = 0, num_checks = 0, c [8];
  assign lamps = {cr, cg, mr, mg, nr, ng};
  always #2 ref_clk = ~ref_clk;
  field_side_model field_side_model_inst (.sensor_current(cur),
    .dc_active(dca));
  resolver_status_preset_logic #(.BLINK_CYCLES(4))
    resolver_status_preset_logic_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat),
    .avs_waitrequest(wq), .dc_active(dca), .pos_valid(pv),
    .first_channel_pos(fp), .second_channel_pos('0), .soft_fault(sf),
    .hard_fault(hf), .module_fault(mf), .coproc_comm_fail(cf),
    .phy_link_up(lk), .net_operational(op), .addr_changed(ac),
    .nv_write_fail(nv), .dup_ip_detected(di), .proto_ethernet_ip(pe),
    .chan_led_red(cr), .chan_led_green(cg),
    .module_health_indicator_red(mr), .module_health_indicator_green(mg),
    .network_link_indicator_red(nr), .network_link_indicator_green(ng));
  // Compare and count
  task chk(input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task w(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // One Avalon access, held until waitrequest is sampled low
  task bus(input logic we, input logic [4:0] a, input logic [31:0] d);
    int i;
    adr <= a; wd <= d; wr <= we; rd <= !we; i = 0;
    do begin @(posedge ref_clk); i++; end while (wq !== 1'b0 && i < 40);
    q = rdat; wr <= 0; rd <= 0;
    if (i >= 40) begin
      n_fail++;
      test_done;
    end
    w(1);
  endtask
  // Count lit cycles of every lamp over 16 cycles
  task samp;
    foreach (c[k]) c[k] = 0;
    repeat (16) begin
      @(posedge ref_clk);
      foreach (c[k]) c[k] += lamps[k];
    end
  endtask
  task t_preset;
    bus(0, OFS_PRE1, 0); chk(q, 32'h0);
    bus(1, OFS_FS0, 8); bus(1, OFS_PRE0, 20);
    bus(0, OFS_PRE0, 0); chk(q, 32'h7);
    pv <= 2'b01; fp <= 18'h00005; w(1); pv <= 0; w(1);
    bus(0, OFS_POS0, 0); chk(q, 32'h5);
    cur <= 2'b01; pv <= 2'b01; fp <= 18'h00009; w(1); pv <= 0; w(2);
    bus(0, OFS_POS0, 0); chk(q, 32'h7);
    bus(1, OFS_PRE1, 3); bus(1, OFS_CTRL, 32'h20);
    bus(0, OFS_POS1, 0); chk(q, 32'h3);
    bus(0, OFS_STATUS, 0); chk(q[1:0], 2'h1);
    cur <= 0; w(1);
    $display("preset test ends");
  endtask
  task t_chan;
    mf <= 1; bus(1, OFS_CTRL, 3); w(2);
    chk({cr, cg}, 4'hC);
    mf <= 0; w(3); chk({cr, cg}, 4'h0);
    bus(1, OFS_CTRL, 4); hf <= 2; sf <= 1; w(3);
    sf <= 0; samp;
    chk(c[7], 8);
    chk(c[4], 8);
    chk(c[6] + c[5], 0);
    hf <= 0; bus(1, OFS_CTRL, 32'h44); w(3);
    chk({cr, cg}, 4'h3);
    $display("channel test ends");
  endtask
  task t_net;
    samp; chk(c[2], 8);
    lk <= 1; op <= 1; w(3); samp;
    chk(c[2], 16);
    di <= 1; w(3); samp; chk(c[1], 16);
    ac <= 1; w(1); ac <= 0; w(3); samp;
    chk(c[3], 8);
    chk(c[1], 8);
    cf <= 1; w(1); cf <= 0; w(3); samp;
    chk(c[3] + c[2], 16);
    chk(c[3], 8);
    $display("network test ends");
  endtask
  task t_nv;
    rst_b <= 0; w(4); rst_b <= 1; w(1);
    bus(0, OFS_PRE1, 0); chk(q, 32'h0);
    samp; chk(c[2], 16);
    nv <= 1; w(1); nv <= 0; w(3); samp;
    chk(c[3], 8);
    chk(c[1] + c[2], 16);
    pe <= 0; w(3); samp; chk(c[1] + c[0], 0);
    $display("flash test ends");
  endtask
  task test_done;
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    w(4); rst_b <= 1; w(1);
    t_preset; t_chan; t_net; t_nv;
    test_done;
  end
  // Hang guard
  initial begin
    w(20000); n_fail++; test_done;
  end
endmodule // tb
